// *** hdl/cbu_defines.vh ***
// Constants for the conditional branch unit.
// Assumes inclusion by hdl/cbu_branch_unit.v only.
`ifndef CBU_DEFINES_VH
`define CBU_DEFINES_VH

// Status flag register bit positions
`define CBU_FLAG_C          3'd0
`define CBU_FLAG_Z          3'd1
`define CBU_FLAG_N          3'd2
`define CBU_FLAG_V          3'd3
`define CBU_FLAG_S          3'd4
`define CBU_FLAG_H          3'd5
`define CBU_FLAG_T          3'd6
`define CBU_FLAG_I          3'd7

// Operation codes on OP
`define CBU_OP_SEL_SET      5'h00
`define CBU_OP_SEL_CLEAR    5'h01
`define CBU_OP_EQUAL        5'h02
`define CBU_OP_NOT_EQUAL    5'h03
`define CBU_OP_CARRY_SET    5'h04
`define CBU_OP_UNS_LOWER    5'h05
`define CBU_OP_CARRY_CLEAR  5'h06
`define CBU_OP_SAME_HIGHER  5'h07
`define CBU_OP_NEGATIVE     5'h08
`define CBU_OP_POSITIVE     5'h09
`define CBU_OP_SIGNED_GE    5'h0a
`define CBU_OP_SIGNED_LT    5'h0b
`define CBU_OP_HALF_SET     5'h0c
`define CBU_OP_HALF_CLEAR   5'h0d
`define CBU_OP_T_SET        5'h0e
`define CBU_OP_T_CLEAR      5'h0f
`define CBU_OP_OVF_SET      5'h10

// Reset values
`define CBU_PC_RESET        16'h0000

// Cycle counts
`define CBU_CYCLES_NOT_TAKEN 2'd1
`define CBU_CYCLES_TAKEN     2'd2

`endif

// *** hdl/cbu_branch_unit.v ***
// Conditional relative branch unit of the processor core.
// Assumes one core clock; the decoder presents OP, BIT_SEL and OFFSET with a one-cycle START
// pulse and holds off the next START while BUSY is high; the core reads PC_OUT.
`timescale 1ns/1ns
`include "cbu_defines.vh"

module cbu_branch_unit #(
  parameter PC_W  = 16,                    // Program counter width
  parameter OFF_W = 7                      // Offset field width
) (
  input  wire             CLK,             // Core clock, 250 MHz
  input  wire             RESET_N,         // Asynchronous reset, active low
  input  wire             START,           // Branch instruction issued, one-cycle pulse
  input  wire [4:0]       OP,              // Branch operation code
  input  wire [2:0]       BIT_SEL,         // Selected flag for generic branches
  input  wire [OFF_W-1:0] OFFSET,          // Signed word offset
  input  wire [PC_W-1:0]  PC_IN,           // Address of the branch instruction
  input  wire [7:0]       FLAGS_IN,        // Status flag register contents
  output wire             BUSY,            // Second cycle of a taken branch
  output reg              DONE,            // Branch completed, one-cycle pulse
  output reg              TAKEN,           // Last branch was taken
  output reg              FLUSH,           // Discard the sequential fetch, one-cycle pulse
  output reg              PC_LOAD,         // Load PC_OUT into the PC, one-cycle pulse
  output reg  [PC_W-1:0]  PC_OUT,          // Next program counter value
  output wire [7:0]       FLAGS_OUT,       // Status flags, passed unchanged
  output reg  [1:0]       CYCLES           // Cycles used by the last branch
);

  localparam [1:0] ST_IDLE  = 2'b01;
  localparam [1:0] ST_FLUSH = 2'b10;

  reg  [1:0]      state_q;
  reg  [1:0]      state_d;
  reg             cond;
  wire            f_c = FLAGS_IN[`CBU_FLAG_C];
  wire            f_z = FLAGS_IN[`CBU_FLAG_Z];
  wire            f_n = FLAGS_IN[`CBU_FLAG_N];
  wire            f_v = FLAGS_IN[`CBU_FLAG_V];
  wire            f_h = FLAGS_IN[`CBU_FLAG_H];
  wire            f_t = FLAGS_IN[`CBU_FLAG_T];
  wire [PC_W-1:0] off_ext;
  wire [PC_W-1:0] target;

  // Sign extension of the offset field
  assign off_ext = {{(PC_W-OFF_W){OFFSET[OFF_W-1]}}, OFFSET};
  assign target  = PC_IN + off_ext + {{(PC_W-1){1'b0}}, 1'b1};

  // Flags are never written here
  assign FLAGS_OUT = FLAGS_IN;
  assign BUSY      = (state_q == ST_FLUSH);

  // Condition evaluation
  always @* begin
    case (OP)
      `CBU_OP_SEL_SET:     cond = FLAGS_IN[BIT_SEL];
      `CBU_OP_SEL_CLEAR:   cond = ~FLAGS_IN[BIT_SEL];
      `CBU_OP_EQUAL:       cond = f_z;
      `CBU_OP_NOT_EQUAL:   cond = ~f_z;
      `CBU_OP_CARRY_SET:   cond = f_c;
      `CBU_OP_UNS_LOWER:   cond = f_c;
      `CBU_OP_CARRY_CLEAR: cond = ~f_c;
      `CBU_OP_SAME_HIGHER: cond = ~f_c;
      `CBU_OP_NEGATIVE:    cond = f_n;
      `CBU_OP_POSITIVE:    cond = ~f_n;
      `CBU_OP_SIGNED_GE:   cond = ~(f_n ^ f_v);
      `CBU_OP_SIGNED_LT:   cond = f_n ^ f_v;
      `CBU_OP_HALF_SET:    cond = f_h;
      `CBU_OP_HALF_CLEAR:  cond = ~f_h;
      `CBU_OP_T_SET:       cond = f_t;
      `CBU_OP_T_CLEAR:     cond = ~f_t;
      `CBU_OP_OVF_SET:     cond = f_v;
      default:             cond = 1'b0;
    endcase
  end

  always @* begin
    case (state_q)
      ST_IDLE:  state_d = (START && cond) ? ST_FLUSH : ST_IDLE;
      ST_FLUSH: state_d = ST_IDLE;
      default:  state_d = ST_IDLE;
    endcase
  end

  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_q <= ST_IDLE;
      DONE    <= 1'b0;
      TAKEN   <= 1'b0;
      FLUSH   <= 1'b0;
      PC_LOAD <= 1'b0;
      PC_OUT  <= `CBU_PC_RESET;
      CYCLES  <= 2'd0;
    end else begin
      state_q <= state_d;
      DONE    <= 1'b0;
      FLUSH   <= 1'b0;
      PC_LOAD <= 1'b0;
      if (state_q == ST_IDLE && START) begin
        TAKEN <= cond;
        if (cond) begin
          // Taken: load target now, finish after the flush cycle
          PC_OUT  <= target;
          PC_LOAD <= 1'b1;
          FLUSH   <= 1'b1;
        end else begin
          PC_OUT <= PC_IN + {{(PC_W-1){1'b0}}, 1'b1};
          DONE   <= 1'b1;
          CYCLES <= `CBU_CYCLES_NOT_TAKEN;
        end
      end else if (state_q == ST_FLUSH) begin
        DONE   <= 1'b1;
        CYCLES <= `CBU_CYCLES_TAKEN;
      end
    end
  end

endmodule // cbu_branch_unit

// *** bench/cbu_sva.sv ***
// Port timing checker for the branch unit.
// Assumes binding onto cbu_branch_unit.
`timescale 1ns/1ns
module cbu_sva #(parameter PC_W = 16, parameter OFF_W = 7) (
  input wire CLK, RESET_N, START, BUSY, DONE, TAKEN, FLUSH, PC_LOAD,
  input wire [4:0] OP,
  input wire [OFF_W-1:0] OFFSET,
  input wire [PC_W-1:0] PC_IN, PC_OUT,
  input wire [7:0] FLAGS_IN, FLAGS_OUT,
  input wire [1:0] CYCLES
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  wire [PC_W-1:0] off_x = {{(PC_W-OFF_W){OFFSET[OFF_W-1]}}, OFFSET};
  wire go = START && !BUSY;
  property p_flags; FLAGS_OUT == FLAGS_IN; endproperty
  a_flags: assert property (p_flags) else $error("flags");
  property p_one; go |=> DONE != PC_LOAD; endproperty
  a_one: assert property (p_one) else $error("first");
  property p_tk; PC_LOAD |-> FLUSH && TAKEN && BUSY ##1 DONE && CYCLES == 2'd2; endproperty
  a_tk: assert property (p_tk) else $error("taken");
  property p_nt; DONE && !$past(PC_LOAD) |-> !TAKEN && CYCLES == 2'd1; endproperty
  a_nt: assert property (p_nt) else $error("untaken");
  property p_pc; go |=> PC_OUT == $past(PC_IN) + 1'b1 + (PC_LOAD ? $past(off_x) : {PC_W{1'b0}});
  endproperty
  a_pc: assert property (p_pc) else $error("target");
  property p_busy; BUSY |=> !BUSY && !PC_LOAD; endproperty
  a_busy: assert property (p_busy) else $error("busy");
  property p_eq; go && OP == 5'h02 |=> TAKEN == $past(FLAGS_IN[1]); endproperty
  a_eq: assert property (p_eq) else $error("equal");
  property p_vs; go && OP == 5'h10 |=> TAKEN == $past(FLAGS_IN[3]); endproperty
  a_vs: assert property (p_vs) else $error("overflow");
endmodule // cbu_sva
bind cbu_branch_unit cbu_sva #(.PC_W(PC_W), .OFF_W(OFF_W)) i_cbu_sva (
  .CLK(CLK), .RESET_N(RESET_N),
  .START(START), .BUSY(BUSY), .DONE(DONE), .TAKEN(TAKEN), .FLUSH(FLUSH), .PC_LOAD(PC_LOAD),
  .OP(OP), .OFFSET(OFFSET), .PC_IN(PC_IN), .PC_OUT(PC_OUT), .FLAGS_IN(FLAGS_IN),
  .FLAGS_OUT(FLAGS_OUT), .CYCLES(CYCLES));

// *** bench/tb_top.sv ***
// Random bench for the branch unit.
// Assumes the unit ignores start while busy; start is held high throughout.
`timescale 1ns/1ns
module tb_top;
  reg clk, reset_n, start, tk;
  reg [4:0] op;
  reg [2:0] bit_sel;
  reg [6:0] offset;
  reg [15:0] pc_in, tgt;
  reg [7:0] flags_in;
  wire busy, done, taken, flush, pc_load;
  wire [15:0] pc_out;
  wire [7:0] flags_out;
  wire [1:0] cycles;
  integer miscompares, checks_done, seed, i;
  cbu_branch_unit i_cbu_branch_unit (.CLK(clk), .RESET_N(reset_n), .START(start), .OP(op),
    .BIT_SEL(bit_sel), .OFFSET(offset), .PC_IN(pc_in), .FLAGS_IN(flags_in), .BUSY(busy),
    .DONE(done), .TAKEN(taken), .FLUSH(flush), .PC_LOAD(pc_load), .PC_OUT(pc_out),
    .FLAGS_OUT(flags_out), .CYCLES(cycles));
  function exp_tk(input [4:0] o, input [2:0] s, input [7:0] f);
    case (o)
      5'h00, 5'h01: exp_tk = f[s] ^ o[0];
      5'h02, 5'h03: exp_tk = f[1] ^ o[0];
      5'h04, 5'h05, 5'h06, 5'h07: exp_tk = f[0] ^ o[1];
      5'h08, 5'h09: exp_tk = f[2] ^ o[0];
      5'h0a, 5'h0b: exp_tk = f[2] ^ f[3] ^ !o[0];
      5'h0c, 5'h0d: exp_tk = f[5] ^ o[0];
      5'h0e, 5'h0f: exp_tk = f[6] ^ o[0];
      5'h10: exp_tk = f[3];
      default: exp_tk = 1'b0;
    endcase
  endfunction
  task chk(input [15:0] got, input [15:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("checks=%0d miscompares=%0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  initial forever #2 clk = !clk;
  initial begin
    {clk, reset_n, start, op, bit_sel, offset, pc_in, flags_in, miscompares, checks_done} = 0;
    seed = 8594;
    repeat (8) @(posedge clk);
    #1 reset_n = 1;
    start = 1;
    // First 19 ops in order with wrap corners; start stays high, so busy restarts are refused
    for (i = 0; i < 400; i = i + 1) begin
      op = (i < 19) ? i[4:0] : $unsigned($random(seed)) % 19;
      bit_sel = $random(seed);
      flags_in = $random(seed);
      offset = (i < 19) ? {i[0], {6{!i[0]}}} : $random(seed);
      pc_in = (i < 19) ? 16'hffff : $random(seed);
      tk = exp_tk(op, bit_sel, flags_in);
      tgt = pc_in + 16'h1 + (tk ? {{9{offset[6]}}, offset} : 16'h0);
      @(posedge clk);
      #1 chk({flags_out, busy, done, pc_load, flush}, {flags_in, tk, !tk, tk, tk});
      chk(taken, tk);
      chk(pc_out, tgt);
      if (tk) begin
        @(posedge clk);
        #1 chk({busy, done, pc_load, cycles}, 5'h0a);
      end else chk(cycles, 16'h1);
    end
    start = 0;
    give_verdict;
  end
endmodule // tb_top
